// ---- logic/terminal_kbd_printer_port.sv ----
// APB controller between the host bus and a hard-copy terminal
`default_nettype none
module terminal_kbd_printer_port (
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [term_port_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire term_port_pkg::key_link_t       key_link,
  input  wire logic                           strap_option_one,
  input  wire logic                           strap_option_two,
  input  wire logic                           printer_demand,
  output term_port_pkg::print_link_t          print_link,
  output logic                                irq_a,
  output logic                                irq_b
);
  import term_port_pkg::*;

  // Match of an address against the byte address of a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [2:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  logic [6:0] kbd_buf_reg;
  logic       kbd_ready_reg;
  logic       kbd_ie_reg;
  logic       ptr_ready_reg;
  logic       ptr_ie_reg;
  logic       maintenance_loop_reg;
  logic       key_prev_reg;
  logic       demand_prev_reg;
  logic [6:0] pdata_n_reg;
  logic       pstrobe_n_reg;
  logic [2:0] pcnt_reg;
  logic       irq_a_reg;
  logic       irq_b_reg;
  logic [31:0] prdata_reg;
  logic       pready_reg;
  logic       pslverr_reg;

  // Bus phase decode
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable & pready_reg;
  wire wr_low   = access & pwrite & pstrb[0];
  wire rd_acc   = access & ~pwrite;
  wire hit_ks   = hit(paddr, IDX_KBD_STAT);
  wire hit_kb   = hit(paddr, IDX_KBD_BUF);
  wire hit_ps   = hit(paddr, IDX_PTR_STAT);
  wire hit_pb   = hit(paddr, IDX_PTR_BUF);
  wire mapped   = hit_ks | hit_kb | hit_ps | hit_pb;

  // Register strobes
  wire ks_wr = wr_low & hit_ks;
  wire ps_wr = wr_low & hit_ps;
  wire pb_wr = wr_low & hit_pb;
  wire kb_rd = rd_acc & hit_kb;

  // Terminal edge detection on synchronous inputs
  wire key_fall    = key_prev_reg & ~key_link.strobe_n;
  wire demand_rise = ~demand_prev_reg & printer_demand;
  wire loop_set    = maintenance_loop_reg & pb_wr;

  // Flag next values; a set always beats a clear
  wire kbd_ready_next = key_fall | loop_set
                      | (kbd_ready_reg & ~kb_rd);
  wire ptr_ready_next = printer_demand
                      & (demand_rise
                      | (ptr_ready_reg & ~pb_wr));
  wire kbd_ie_next = ks_wr ? pwdata[IE_BIT] : kbd_ie_reg;
  wire ptr_ie_next = ps_wr ? pwdata[IE_BIT] : ptr_ie_reg;

  // Strap-selected eighth bit of the keyboard buffer
  wire both_straps = strap_option_one & strap_option_two;
  wire kb_bit7 = strap_option_one ? ~maintenance_loop_reg
               : strap_option_two ? 1'b0
               : 1'b1;
  wire [7:0] kb_byte = both_straps ? 8'h00
                     : {kb_bit7, kbd_buf_reg};

  // Read data selection
  wire [7:0] ks_byte = {kbd_ready_reg, kbd_ie_reg, 6'h00};
  wire [7:0] ps_byte = {ptr_ready_reg, ptr_ie_reg,
                        3'h0, maintenance_loop_reg, 2'h0};
  wire [7:0] rd_byte = hit_ks ? ks_byte
                     : hit_kb ? kb_byte
                     : hit_ps ? ps_byte
                     : 8'h00;

  // APB answer: one wait-free access phase after each setup
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~mapped;
      prdata_reg  <= (setup_ph & ~pwrite) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // Keyboard buffer and keyboard flags
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_prev_reg  <= 1'b1;
      kbd_buf_reg   <= CHAR_RST;
      kbd_ready_reg <= 1'b0;
      kbd_ie_reg    <= IE_RST;
    end else begin
      key_prev_reg  <= key_link.strobe_n;
      if (key_fall) begin
        kbd_buf_reg <= key_link.code;
      end
      kbd_ready_reg <= kbd_ready_next;
      kbd_ie_reg    <= kbd_ie_next;
    end
  end

  // Printer flags and loop control
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      demand_prev_reg <= 1'b0;
      ptr_ready_reg   <= 1'b0;
      ptr_ie_reg      <= IE_RST;
      maintenance_loop_reg       <= MAINTENANCE_LOOP_RST;
    end else begin
      demand_prev_reg <= printer_demand;
      ptr_ready_reg   <= ptr_ready_next;
      ptr_ie_reg      <= ptr_ie_next;
      if (ps_wr) begin
        maintenance_loop_reg <= pwdata[MAINTENANCE_LOOP_BIT];
      end
    end
  end

  // Printer data and strobe, strobe held STROBE_CYC cycles
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdata_n_reg   <= 7'h7f;
      pstrobe_n_reg <= 1'b1;
      pcnt_reg      <= 3'h0;
    end else if (pb_wr) begin
      pdata_n_reg   <= ~pwdata[6:0];
      pstrobe_n_reg <= 1'b0;
      pcnt_reg      <= 3'(STROBE_CYC - 1);
    end else if (pcnt_reg != 3'h0) begin
      pcnt_reg      <= pcnt_reg - 3'h1;
    end else begin
      pstrobe_n_reg <= 1'b1;
    end
  end

  // Interrupt request levels
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= kbd_ready_next & kbd_ie_next;
      irq_b_reg <= ptr_ready_next & ptr_ie_next;
    end
  end

  // Outputs
  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign print_link          = '{strobe_n: pstrobe_n_reg, data_n: pdata_n_reg};
  assign irq_a               = irq_a_reg;
  assign irq_b               = irq_b_reg;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_key_capture: assert property (
    key_fall |=> kbd_buf_reg == $past(key_link.code))
    else $error("key code not captured");

  a_kbd_hold: assert property (
    !key_fall |=> kbd_buf_reg == $past(kbd_buf_reg))
    else $error("keyboard buffer changed without strobe");

  a_kbd_ready_set: assert property (
    key_fall |=> kbd_ready_reg)
    else $error("key strobe did not set ready");

  a_irq_a_level: assert property (
    irq_a == (kbd_ready_reg & kbd_ie_reg))
    else $error("request A mismatch");

  a_read_clears: assert property (
    kb_rd && !key_fall && !loop_set |=> !kbd_ready_reg)
    else $error("buffer read kept ready");

  a_kbuf_read: assert property (
    setup_ph && !pwrite && hit_kb && !both_straps
    |=> prdata[6:0] == $past(kbd_buf_reg))
    else $error("buffer read data wrong");

  a_strap_zero: assert property (
    setup_ph && !pwrite && hit_kb && both_straps
    |=> prdata == 32'h0)
    else $error("both straps not zero");

  a_ptr_demand: assert property (
    !printer_demand |=> !ptr_ready_reg)
    else $error("printer ready set without demand");

  a_ptr_clear: assert property (
    pb_wr && !demand_rise |=> !ptr_ready_reg)
    else $error("print write kept ready");

  a_irq_b_gate: assert property (
    irq_b == (ptr_ready_reg & ptr_ie_reg))
    else $error("request B mismatch");

  a_pstrobe_pulse: assert property (
    pb_wr |=> !print_link.strobe_n [*4])
    else $error("print strobe too short");

  a_pstrobe_end: assert property (
    pb_wr ##1 !pb_wr [*4] |=> print_link.strobe_n)
    else $error("print strobe too long");

  a_pdata_inv: assert property (
    pb_wr |=> print_link.data_n == ~$past(pwdata[6:0]))
    else $error("printer data not inverted");

  a_loop_set: assert property (
    maintenance_loop_reg && pb_wr |=> kbd_ready_reg)
    else $error("loop did not set keyboard ready");

  a_kie_load: assert property (
    ks_wr |=> kbd_ie_reg == $past(pwdata[IE_BIT]))
    else $error("keyboard enable load wrong");

  a_kstat_read: assert property (
    setup_ph && !pwrite && hit_ks |=> prdata[7] == $past(kbd_ready_reg))
    else $error("keyboard status ready bit wrong");

  a_strap_one: assert property (
    setup_ph && !pwrite && hit_kb && strap_option_one && !strap_option_two
    |=> prdata[7] == ~$past(maintenance_loop_reg))
    else $error("strap one bit 7 wrong");

  a_strap_two: assert property (
    setup_ph && !pwrite && hit_kb && !strap_option_one && strap_option_two
    |=> !prdata[7])
    else $error("strap two bit 7 not zero");

  a_strap_none: assert property (
    setup_ph && !pwrite && hit_kb && !strap_option_one && !strap_option_two
    |=> prdata[7])
    else $error("no strap bit 7 not high");

  a_ptr_set: assert property (
    demand_rise |=> ptr_ready_reg)
    else $error("demand rise did not set printer ready");

  a_pstat_read: assert property (
    setup_ph && !pwrite && hit_ps |=> prdata[7] == $past(ptr_ready_reg))
    else $error("printer status ready bit wrong");

  a_ptr_hold: assert property (
    ptr_ready_reg && printer_demand && !pb_wr |=> ptr_ready_reg)
    else $error("printer ready dropped without cause");

  a_ptr_no_spurious: assert property (
    !demand_rise && !ptr_ready_reg |=> !ptr_ready_reg)
    else $error("printer ready set without demand rise");

  a_pie_load: assert property (
    ps_wr |=> ptr_ie_reg == $past(pwdata[IE_BIT]))
    else $error("printer enable load wrong");

  a_irq_b_clear: assert property (
    pb_wr && !demand_rise |=> !irq_b)
    else $error("request B kept after print write");

  a_kbd_keep: assert property (
    kbd_ready_reg && !kb_rd |=> kbd_ready_reg)
    else $error("keyboard ready dropped without read");

  a_kbd_no_spurious: assert property (
    !key_fall && !loop_set && !kbd_ready_reg |=> !kbd_ready_reg)
    else $error("keyboard ready set without cause");

  a_kie_hold: assert property (
    !ks_wr |=> kbd_ie_reg == $past(kbd_ie_reg))
    else $error("keyboard enable changed without write");

  a_ie_split: assert property (
    ks_wr |=> ptr_ie_reg == $past(ptr_ie_reg))
    else $error("keyboard status write hit printer enable");

  a_maintenance_loop_load: assert property (
    ps_wr |=> maintenance_loop_reg == $past(pwdata[MAINTENANCE_LOOP_BIT]))
    else $error("loop flop load wrong");

  a_pdata_hold: assert property (
    !pb_wr |=> print_link.data_n == $past(print_link.data_n))
    else $error("printer data changed without write");

  a_strobe_idle: assert property (
    print_link.strobe_n && !pb_wr |=> print_link.strobe_n)
    else $error("print strobe without buffer write");

  a_strobe_gate: assert property (
    $fell(print_link.strobe_n) |-> $past(pb_wr))
    else $error("print strobe fell without write");

  a_strb_ignore: assert property (
    access && pwrite && hit_pb && !pstrb[0] && print_link.strobe_n
    |=> print_link.strobe_n)
    else $error("print strobe without low byte");

  c_key_read: cover property (key_fall ##[1:20] kb_rd);
  c_print: cover property (pb_wr ##[1:50] demand_rise);
  c_loop: cover property (loop_set ##1 irq_a);
  c_unmapped: cover property (pslverr);
  c_strap_both: cover property (setup_ph && !pwrite && hit_kb && both_straps);
endmodule : terminal_kbd_printer_port
`default_nettype wire

// ---- logic/term_port_pkg.sv ----
// Constants and carrier types for the terminal keyboard/printer port
`default_nettype none
package term_port_pkg;
  // APB address width and register indexes (byte address = 4 * index)
  localparam int unsigned ADDR_W        = 5;
  localparam logic [2:0]  IDX_KBD_STAT  = 3'h0;
  localparam logic [2:0]  IDX_KBD_BUF   = 3'h2;
  localparam logic [2:0]  IDX_PTR_STAT  = 3'h4;
  localparam logic [2:0]  IDX_PTR_BUF   = 3'h6;
  // Field positions
  localparam int unsigned CHAR_W        = 7;
  localparam int unsigned READY_BIT     = 7;
  localparam int unsigned IE_BIT        = 6;
  localparam int unsigned MAINTENANCE_LOOP_BIT     = 2;
  localparam int unsigned STRAP_BIT     = 7;
  // Reset values
  localparam logic        IE_RST        = 1'b0;
  localparam logic        MAINTENANCE_LOOP_RST     = 1'b0;
  localparam logic [6:0]  CHAR_RST      = 7'h00;
  // Print strobe width
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STROBE_NS     = 20;
  localparam int unsigned STROBE_CYC    =
    (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Keyboard side of the terminal link
  typedef struct packed {
    logic       strobe_n;
    logic [6:0] code;
  } key_link_t;
  // Printer side of the terminal link
  typedef struct packed {
    logic       strobe_n;
    logic [6:0] data_n;
  } print_link_t;
endpackage : term_port_pkg
`default_nettype wire

// ---- dv/term_model.sv ----
// Terminal keyboard and printer model for the port bench
`default_nettype none
module term_model (
  input  wire logic                   sys_clk,
  input  wire term_port_pkg::print_link_t print_link,
  output term_port_pkg::key_link_t    key_link,
  output logic                        printer_demand
);
  timeunit 1ns;
  timeprecision 1ps;
  import term_port_pkg::*;
  int busy = 0;
  initial key_link = {1'b1, 7'h55};
  initial printer_demand = 1'b1;
  // Drop demand while a character is taken and printed
  always @(posedge sys_clk) begin
    if (!print_link.strobe_n) begin
      printer_demand <= 1'b0;
      busy <= 20;
    end else if (busy > 1) busy <= busy - 1;
    else if (busy == 1) begin
      busy <= 0;
      printer_demand <= 1'b1;
    end
  end
  // Code settles before the strobe; released lines show the inverse
  task automatic send_key(input logic [6:0] c);
    @(posedge sys_clk) key_link.code <= c;
    @(posedge sys_clk) key_link.strobe_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    key_link.strobe_n <= 1'b1;
    @(posedge sys_clk) key_link.code <= ~c;
  endtask : send_key
endmodule : term_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the terminal keyboard and printer port
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import term_port_pkg::*;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic s1 = 1, s2 = 0, pready, pslverr, printer_demand, irq_a, irq_b, e;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [6:0] c;
  logic [3:0] pstrb = 4'hf;
  key_link_t key_link;
  print_link_t print_link;
  int miscompares = 0, tests_run = 0, seed = 32'h8f86;
  always #2.5 sys_clk = ~sys_clk;
  terminal_kbd_printer_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_link(key_link), .strap_option_one(s1),
    .strap_option_two(s2), .printer_demand(printer_demand),
    .print_link(print_link), .irq_a(irq_a), .irq_b(irq_b));
  term_model i_term (.sys_clk(sys_clk), .print_link(print_link),
    .key_link(key_link), .printer_demand(printer_demand));
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  // Poll printer status until ready, bounded
  task automatic wait_rdy();
    int i;
    r = '0;
    for (i = 0; i < 100 && r[7] !== 1'b1; i++) apb(1'b0, 5'h10, 32'h0);
  endtask : wait_rdy
  // Keyboard buffer read value from key code, straps and loop flop
  function automatic logic [31:0] kexp(logic [6:0] k, logic a, logic b, logic m);
    logic [7:0] v;
    v = {a ? ~m : 1'b1, k};
    if (b) v[7] = 1'b0;
    if (a && b) v = 8'h00;
    return {24'h0, v};
  endfunction : kexp
  task automatic print_verdict();
    $display("Compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Watchdog against a hung handshake
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(print_link, 8'hff)
    `CHK(irq_b, 1'b0)
    apb(1'b0, 5'h04, 32'h0);
    `CHK({e, r}, 33'h1_0000_0000)
    for (int s = 0; s < 4; s++) begin
      {s1, s2} <= s[1:0];
      c = 7'($random(seed));
      i_term.send_key(c);
      apb(1'b0, 5'h00, 32'h0);
      `CHK(r, 32'h80)
      apb(1'b0, 5'h08, 32'h0);
      `CHK(r, kexp(c, s1, s2, 1'b0))
      apb(1'b0, 5'h00, 32'h0);
      `CHK(r, 32'h0)
    end
    // Interrupt A, then an unread key lost to the next one
    {s1, s2} <= 2'b10;
    apb(1'b1, 5'h00, 32'h40);
    i_term.send_key(7'h2a);
    `CHK(irq_a, 1'b1)
    c = 7'($random(seed));
    i_term.send_key(c);
    apb(1'b0, 5'h08, 32'h0);
    `CHK(r, kexp(c, 1'b1, 1'b0, 1'b0))
    @(posedge sys_clk);
    `CHK(irq_a, 1'b0)
    // Printed characters paced by the ready flag
    apb(1'b1, 5'h10, 32'h40);
    pstrb <= 4'he;
    apb(1'b1, 5'h18, 32'h55);
    pstrb <= 4'hf;
    `CHK(print_link, 8'hff)
    for (int k = 0; k < 3; k++) begin
      wait_rdy();
      `CHK(r[7], 1'b1)
      `CHK(irq_b, 1'b1)
      c = 7'($random(seed));
      apb(1'b1, 5'h18, {25'h0, c});
      `CHK(print_link, {1'b0, ~c})
      apb(1'b0, 5'h10, 32'h0);
      `CHK(r, 32'h40)
    end
    // Loop mode: a printer buffer write raises keyboard ready
    wait_rdy();
    `CHK(r[7], 1'b1)
    apb(1'b1, 5'h10, 32'h44);
    apb(1'b1, 5'h18, 32'h41);
    apb(1'b0, 5'h00, 32'h0);
    `CHK(r, 32'hc0)
    apb(1'b0, 5'h08, 32'h0);
    `CHK(r[7], 1'b0)
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
